// >>> logic/tmr_pkg.sv
// Purpose: constants shared by the configurable 8/16-bit timer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   byte address of a register is four times its index
package tmr_pkg;
  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 32;
  localparam logic [13:0] IDX_LO      = 14'h059C;
  localparam logic [13:0] IDX_HI      = 14'h059D;
  localparam logic [13:0] IDX_CA      = 14'h059E;
  localparam logic [13:0] IDX_CB      = 14'h059F;
  localparam logic [13:0] IDX_ST      = 14'h05A0;
  localparam logic [ADDR_W-1:0] ADDR_LO = {IDX_LO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_HI = {IDX_HI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CA = {IDX_CA, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CB = {IDX_CB, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ST = {IDX_ST, 2'b00};
  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [7:0] CA_WMASK     = 8'h9F;
  localparam int         CA_ON_BIT    = 7;
  localparam int         CA_OUT_BIT   = 5;
  localparam int         CA_W16_BIT   = 4;
  localparam int         CA_PS_LSB    = 0;
  localparam int         CB_CS_LSB    = 5;
  localparam int         CB_ASYNC_BIT = 4;
  localparam int         CB_CKPS_LSB  = 0;
  localparam int         ST_FLAG_BIT  = 0;
  localparam int         ST_IE_BIT    = 1;
  localparam int         PRE_SEL_W    = 4;
  localparam int         POST_W       = 4;
  localparam int         CS_W         = 3;
  localparam int         N_SRC        = 6;
  localparam logic [7:0] CNT_MAX      = 8'hFF;
endpackage

// >>> logic/tmr_pre_if.sv
// Purpose: link between timer core and its input prescaler
// Assumes: single clock domain
// Notes:   tick_out is combinational from tick_in
`timescale 1ns/10ps
interface tmr_pre_if #(parameter int SEL_W = 4);
  logic             tick_in;
  logic [SEL_W-1:0] sel;
  logic             clr;
  logic             tick_out;
  modport prs (input tick_in, input sel, input clr, output tick_out);
  modport ctl (output tick_in, output sel, output clr, input tick_out);
endinterface

// >>> logic/tmr_prescaler.sv
// Purpose: power-of-two divider on the timer's count ticks
// Assumes: tick_in is a one-cycle pulse per selected source edge
// Notes:   counter is hidden from software
`timescale 1ns/10ps
module tmr_prescaler
  import tmr_pkg::*;
#(
  parameter int SEL_W = PRE_SEL_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core side
  tmr_pre_if.prs   pre
);
  localparam int CNT_W = (1 << SEL_W) - 1;

  // refuse widths that the 32-bit mask arithmetic cannot serve
  if (SEL_W < 1 || SEL_W > 5) begin : g_bad_width
    $error("prescale select width out of range");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] mask;
  logic             hit;

  // divide by two to the power sel: fire when the low sel bits are all ones
  assign mask         = CNT_W'((32'h1 << pre.sel) - 32'h1);
  assign hit          = pre.tick_in & ((cnt_q & mask) == mask);
  assign pre.tick_out = hit & ~pre.clr;
  assign cnt_d        = pre.clr     ? '0 :
                        pre.tick_in ? cnt_q + 1'b1 : cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// >>> logic/tmr_top.sv
// Purpose: 8-bit period / 16-bit free-running timer behind APB
// Assumes: sources arrive asynchronous and slower than pclk / 2
// Notes:   instruction clock is pclk itself
`timescale 1ns/10ps
module tmr_top
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // clock sources, asynchronous to pclk
  input  wire logic              src_pin,
  input  wire logic              src_hfosc,
  input  wire logic              src_lfosc,
  input  wire logic              src_mfosc,
  input  wire logic              src_sosc,
  input  wire logic              src_cell,
  // power state, from pclk logic
  input  wire logic              sleep_mode,
  // outputs
  output logic                   timer_output,
  output logic                   timer_irq,
  output logic                   wake_req
);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic              pready_q;
  logic [DATA_W-1:0] prdata_q;
  logic              pslverr_q;
  logic              setup;
  logic              done;
  logic              hit_lo;
  logic              hit_hi;
  logic              hit_ca;
  logic              hit_cb;
  logic              hit_st;
  logic              mapped;
  logic              wr_ok;
  logic              wr_lo;
  logic              wr_hi;
  logic              wr_ca;
  logic              wr_cb;
  logic              wr_st;
  logic              rd_lo;

  assign setup  = psel & ~penable;
  assign done   = psel & penable & pready_q;
  assign hit_lo = (paddr == ADDR_LO);
  assign hit_hi = (paddr == ADDR_HI);
  assign hit_ca = (paddr == ADDR_CA);
  assign hit_cb = (paddr == ADDR_CB);
  assign hit_st = (paddr == ADDR_ST);
  assign mapped = hit_lo | hit_hi | hit_ca | hit_cb | hit_st;
  assign wr_ok  = done & pwrite & mapped;
  assign wr_lo  = wr_ok & hit_lo;
  assign wr_hi  = wr_ok & hit_hi;
  assign wr_ca  = wr_ok & hit_ca;
  assign wr_cb  = wr_ok & hit_cb;
  assign wr_st  = wr_ok & hit_st;
  assign rd_lo  = done & ~pwrite & hit_lo;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] cnt_lo_q;
  logic [7:0] cnt_lo_d;
  logic [7:0] cnt_hi_q;
  logic [7:0] cnt_hi_d;
  logic [7:0] hi_reg_q;
  logic [7:0] hi_reg_d;
  logic [7:0] per_buf_q;
  logic [7:0] per_buf_d;
  logic [7:0] snap_q;
  logic       out_q;
  logic       flag_q;
  logic       flag_d;
  logic       ie_q;
  logic       irq_q;
  logic       wake_q;

  logic                 mod_on;
  logic                 w16;
  logic [POST_W-1:0]    post_sel;
  logic [CS_W-1:0]      clk_sel;
  logic                 async_sel;
  logic [PRE_SEL_W-1:0] pre_sel;

  assign mod_on    = ctrl_a_q[CA_ON_BIT];
  assign w16       = ctrl_a_q[CA_W16_BIT];
  assign post_sel  = ctrl_a_q[CA_PS_LSB +: POST_W];
  assign clk_sel   = ctrl_b_q[CB_CS_LSB +: CS_W];
  assign async_sel = ctrl_b_q[CB_ASYNC_BIT];
  assign pre_sel   = ctrl_b_q[CB_CKPS_LSB +: PRE_SEL_W];

  // read mux; output level bit is read-only, reserved bit reads zero
  logic [7:0] rd_ca;
  logic [7:0] rd_st;
  logic [7:0] rd_byte;

  assign rd_ca   = (ctrl_a_q & CA_WMASK) |
                   (8'(out_q) << CA_OUT_BIT);
  assign rd_st   = (8'(flag_q) << ST_FLAG_BIT) |
                   (8'(ie_q) << ST_IE_BIT);
  assign rd_byte = hit_lo ? cnt_lo_q :
                   hit_hi ? hi_reg_q :
                   hit_ca ? rd_ca :
                   hit_cb ? ctrl_b_q :
                   hit_st ? rd_st : REG_RST;

  // ------------------------------------------------------------
  // clock source sampling
  // ------------------------------------------------------------
  // sources are sampled, so each must stay below half of pclk
  logic [N_SRC-1:0] src_raw;
  logic [N_SRC-1:0] s1_q;
  logic [N_SRC-1:0] s2_q;
  logic [N_SRC-1:0] s3_q;
  logic [N_SRC-1:0] rise;
  logic             pin_fall;
  logic             instr_tick;
  logic [7:0]       tick_vec;
  logic             src_tick;

  assign src_raw = {src_cell, src_sosc, src_mfosc,
                    src_lfosc, src_hfosc, src_pin};

  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= src_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
      assign rise[gi] = s2_q[gi] & ~s3_q[gi];
    end
  endgenerate

  // instruction clock is pclk, absent during sleep
  assign pin_fall   = ~s2_q[0] & s3_q[0];
  assign instr_tick = ~sleep_mode;
  assign tick_vec   = {rise[5], rise[4], rise[3], rise[2], rise[1],
                       instr_tick, pin_fall, rise[0]};
  assign src_tick   = tick_vec[clk_sel];

  // ------------------------------------------------------------
  // prescaler and synchroniser stage
  // ------------------------------------------------------------
  logic ctl_clr;
  logic sync_tick_q;
  logic cnt_tick;

  tmr_pre_if #(.SEL_W(PRE_SEL_W)) pre_if ();

  assign ctl_clr        = wr_lo | wr_ca | wr_cb;
  assign pre_if.tick_in = src_tick & mod_on;
  assign pre_if.sel     = pre_sel;
  assign pre_if.clr     = ctl_clr | ~mod_on;

  tmr_prescaler #(.SEL_W(PRE_SEL_W)) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .pre     (pre_if.prs)
  );

  // the synchronised path costs one cycle and halts in sleep
  assign cnt_tick = async_sel ? pre_if.tick_out :
                    (sync_tick_q & ~sleep_mode);

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  logic [15:0] cnt16_inc;
  logic        match8;
  logic        roll16;
  logic        adv;
  logic        event_hit;

  assign cnt16_inc = {cnt_hi_q, cnt_lo_q} + 16'h0001;
  assign match8    = (cnt_lo_q == per_buf_q);
  assign roll16    = (cnt_lo_q == CNT_MAX) & (cnt_hi_q == CNT_MAX);
  assign adv       = cnt_tick & mod_on & ~wr_lo;
  assign event_hit = adv & (w16 ? roll16 : match8);

  assign cnt_lo_d  = wr_lo      ? pwdata[7:0] :
                     ~adv       ? cnt_lo_q :
                     w16        ? cnt16_inc[7:0] :
                     match8     ? REG_RST :
                                  cnt_lo_q + 8'h01;
  assign cnt_hi_d  = (wr_lo & w16) ? hi_reg_q :
                     (adv & w16)   ? cnt16_inc[15:8] : cnt_hi_q;
  assign hi_reg_d  = wr_hi          ? pwdata[7:0] :
                     (rd_lo & w16)  ? snap_q : hi_reg_q;
  assign per_buf_d = (adv & ~w16 & match8) ? hi_reg_q :
                     per_buf_q;

  // ------------------------------------------------------------
  // postscaler, output and flag
  // ------------------------------------------------------------
  logic [POST_W-1:0] post_q;
  logic [POST_W-1:0] post_d;
  logic              post_top;
  logic              toggle;

  assign post_top = (post_q == post_sel);
  assign toggle   = event_hit & post_top & ~ctl_clr;
  assign post_d   = ctl_clr   ? '0 :
                    event_hit ? (post_top ? '0 : post_q + 1'b1) : post_q;
  // set wins over a software clear in the same cycle
  assign flag_d   = toggle |
                    (flag_q & ~(wr_st & pwdata[ST_FLAG_BIT]));

  // ------------------------------------------------------------
  // flip-flops
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
      snap_q    <= REG_RST;
    end else begin
      if (setup) begin
        pready_q  <= 1'b1;
        pslverr_q <= ~mapped;
        prdata_q  <= pwrite ? '0 : DATA_W'(rd_byte);
        snap_q    <= cnt_hi_q;
      end else if (done) begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= REG_RST;
      ctrl_b_q <= REG_RST;
      ie_q     <= 1'b0;
    end else begin
      if (wr_ca) begin
        ctrl_a_q <= pwdata[7:0] & CA_WMASK;
      end
      if (wr_cb) begin
        ctrl_b_q <= pwdata[7:0];
      end
      if (wr_st) begin
        ie_q <= pwdata[ST_IE_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lo_q    <= REG_RST;
      cnt_hi_q    <= REG_RST;
      hi_reg_q    <= REG_RST;
      per_buf_q   <= REG_RST;
      sync_tick_q <= 1'b0;
      post_q      <= '0;
      out_q       <= 1'b0;
      flag_q      <= 1'b0;
    end else begin
      cnt_lo_q    <= cnt_lo_d;
      cnt_hi_q    <= cnt_hi_d;
      hi_reg_q    <= hi_reg_d;
      per_buf_q   <= per_buf_d;
      sync_tick_q <= pre_if.tick_out;
      post_q      <= post_d;
      out_q       <= out_q ^ toggle;
      flag_q      <= flag_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= flag_q & ie_q;
      wake_q <= flag_q & ie_q & sleep_mode;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign timer_output = out_q;
  assign timer_irq    = irq_q;
  assign wake_req     = wake_q;

endmodule

// >>> tb/tmr_properties.sv
// Purpose: bus and output properties of the timer top
// Assumes: one pclk domain, only top ports visible
// Notes:   enable state is mirrored from observed apb writes
`timescale 1ns/10ps
module tmr_properties
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb slave
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // clock sources
  input wire logic              src_pin,
  input wire logic              src_hfosc,
  input wire logic              src_lfosc,
  input wire logic              src_mfosc,
  input wire logic              src_sosc,
  input wire logic              src_cell,
  // power state
  input wire logic              sleep_mode,
  // outputs
  input wire logic              timer_output,
  input wire logic              timer_irq,
  input wire logic              wake_req
);
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  logic on_q;
  wire  wr_ca  = psel && penable && pready && pwrite && (paddr == ADDR_CA);
  wire  mapped = paddr inside {ADDR_LO, ADDR_HI, ADDR_CA, ADDR_CB, ADDR_ST};
  // mirror only; a write that is refused never reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_q <= 1'b0;
    else if (wr_ca) on_q <= pwdata[CA_ON_BIT];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  zero_wait_a: assert property (setup_s |=> access_s)
    else $error("pready missing in first access cycle");
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  err_unmapped_a: assert property (pslverr |-> pready && !mapped)
    else $error("pslverr on mapped address");
  unmapped_err_a: assert property (access_s and !mapped |-> pslverr)
    else $error("unmapped access without pslverr");
  rdata_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed without setup");
  off_hold_a: assert property (!on_q [*3] |-> $stable(timer_output))
    else $error("output moved while module off");
  wake_awake_a: assert property (!sleep_mode [*2] |-> !wake_req)
    else $error("wake request outside sleep");
  cover property (access_s and !mapped);
endmodule

bind tmr_top tmr_properties u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .src_pin, .src_hfosc, .src_lfosc, .src_mfosc,
  .src_sosc, .src_cell, .sleep_mode, .timer_output, .timer_irq, .wake_req
);

// >>> tb/testbench.sv
// Purpose: self-checking bench of the 8/16-bit timer over apb
// Assumes: all clock sources share one free-running 6-cycle wave
// Notes:   intervals are counted in pclk edges between output toggles
`timescale 1ns/10ps
module testbench
  import tmr_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, src, sleep_mode;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              pready, pslverr, timer_output, timer_irq, wake_req;
  int                miscompares, n_tests, cyc, sc, k;
  logic [7:0]        r;
  logic              e;
  // ----------------------------------------------------------
  // clock, sources and timeout
  // ----------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // sources toggle every third edge: high and low stay 3 pclk
  always @(posedge pclk) begin
    sc <= (sc == 2) ? 0 : sc + 1;
    if (sc == 2) src <= ~src;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  tmr_top uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .src_pin(src), .src_hfosc(src), .src_lfosc(src),
    .src_mfosc(src), .src_sosc(src), .src_cell(src), .sleep_mode,
    .timer_output, .timer_irq, .wake_req
  );
  // ----------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       x;
    apb(1'b1, a, d, q, x);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       x;
    apb(1'b0, a, 8'h00, q, x);
    chk8(q, exp);
  endtask
  // edges until timer_output next changes, capped at lim
  task automatic wt(output int n, input int lim);
    logic o;
    o = timer_output;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (timer_output === o && n < lim);
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_LO, 8'h00);
    rd(ADDR_HI, 8'h00);
    rd(ADDR_CB, 8'h00);
    rd(ADDR_ST, 8'h00);
    wr(ADDR_CA, 8'h60);
    rd(ADDR_CA, 8'h00);
    apb(1'b0, 16'h0100, 8'h00, r, e);
    chk8(r, 8'h00);
    chk8({7'h0, e}, 8'h01);
  endtask
  // 8-bit period 1, source code cs, prescale field ps
  task automatic t_rate(input logic [2:0] cs, input logic [3:0] ps,
                        input int exp);
    int n;
    wr(ADDR_CA, 8'h00);
    wr(ADDR_LO, 8'h00);
    wr(ADDR_HI, 8'h01);
    wr(ADDR_CB, {cs, 1'b0, ps});
    wr(ADDR_CA, 8'h80);
    wt(n, 2000);
    wt(n, 2000);
    chkn(n, exp);
  endtask
  task automatic t_period();
    int n;
    wr(ADDR_CA, 8'h00);
    wr(ADDR_LO, 8'h00);
    wr(ADDR_HI, 8'h05);
    wr(ADDR_CB, 8'h40);
    wr(ADDR_CA, 8'h80);
    wt(n, 100);
    wt(n, 100);
    chkn(n, 6);
    // the new period lands mid-period, before the match that reloads it
    fork
      wr(ADDR_HI, 8'h01);
      wt(n, 100);
    join
    chkn(n, 6);
    wt(n, 100);
    chkn(n, 2);
  endtask
  task automatic t_post();
    int n;
    wr(ADDR_ST, 8'h03);
    wr(ADDR_CA, 8'h83);
    wt(n, 100);
    wt(n, 100);
    chkn(n, 8);
    rd(ADDR_ST, 8'h03);
    chk8({7'h0, timer_irq}, 8'h01);
    wr(ADDR_CA, 8'h00);
    apb(1'b0, ADDR_LO, 8'h00, r, e);
    repeat (20) @(posedge pclk);
    rd(ADDR_LO, r);
    wr(ADDR_ST, 8'h03);
    rd(ADDR_ST, 8'h02);
    chk8({7'h0, timer_irq}, 8'h00);
  endtask
  task automatic t_16();
    int n;
    wr(ADDR_CA, 8'h10);
    wr(ADDR_HI, 8'h12);
    wr(ADDR_LO, 8'h34);
    wr(ADDR_HI, 8'h56);
    rd(ADDR_LO, 8'h34);
    rd(ADDR_HI, 8'h12);
    wr(ADDR_HI, 8'hFF);
    wr(ADDR_LO, 8'hF8);
    wr(ADDR_CB, 8'h40);
    wr(ADDR_CA, 8'h90);
    // one sync stage, then 0xFFF8 counts up and rolls on the eighth tick
    wt(n, 200);
    chkn(n, 10);
    apb(1'b0, ADDR_LO, 8'h00, r, e);
    chk8(r, 8'h02);
    rd(ADDR_HI, 8'h00);
  endtask
  task automatic t_sleep();
    int n;
    wr(ADDR_CA, 8'h00);
    wr(ADDR_LO, 8'h00);
    wr(ADDR_HI, 8'h01);
    wr(ADDR_ST, 8'h03);
    wr(ADDR_CB, 8'h70);
    wr(ADDR_CA, 8'h80);
    sleep_mode <= 1'b1;
    wt(n, 200);
    wt(n, 200);
    chkn(n, 12);
    @(posedge pclk);
    chk8({7'h0, wake_req}, 8'h01);
    wr(ADDR_CB, 8'h60);
    wt(n, 100);
    chkn(n, 100);
    sleep_mode <= 1'b0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; sleep_mode = 1'b0; src = 1'b0;
    sc = 0; cyc = 0; miscompares = 0; n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    for (k = 0; k < 8; k++) t_rate(k[2:0], 4'h0, (k == 2) ? 2 : 12);
    for (k = 1; k < 4; k++) t_rate(3'd2, k[3:0], 2 << k);
    t_rate(3'd3, 4'h1, 24);
    t_period();
    t_post();
    t_16();
    t_sleep();
    end_sim();
  end
endmodule
